// ==== shared/ecc_scrub_pkg.sv ====
// Constants, register map and carrier types for the memory error monitor and scrub status block.
// Assumes one system clock; every user writes ecc_scrub_pkg::name, nothing is imported.
package ecc_scrub_pkg;

  // Register byte addresses on the plain register port.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TIMER_COUNT = 8'h04;
  localparam logic [7:0] ADDR_TIMER_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h0C;
  localparam logic [7:0] ADDR_UPPER_LIMIT = 8'h10;
  localparam logic [7:0] ADDR_CORR_A = 8'h14;
  localparam logic [7:0] ADDR_CORR_SWEEP = 8'h18;
  localparam logic [7:0] ADDR_UNCORR_A = 8'h1C;
  localparam logic [7:0] ADDR_LAST_ADDR = 8'h24;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h28;
  localparam logic [7:0] ADDR_EVT_CLEAR = 8'h2C;
  localparam logic [7:0] ADDR_EVT_ENABLE = 8'h30;

  // Field positions.
  localparam int CTRL_SCRUB_EN_BIT = 0;
  localparam int CTRL_IRQ_EN_BIT = 2;
  localparam int FLAG_BIT = 0;

  // Widths.
  localparam int BUS_AW = 8;
  localparam int DATA_W = 32;
  localparam int LIMIT_W = 15;
  localparam int TALLY_W = 16;
  localparam int ADDR_A_W = 17;

  // Reset values and the minimum timer reload.
  localparam logic CTRL_SCRUB_EN_RESET = 1'b1;
  localparam logic CTRL_IRQ_EN_RESET = 1'b0;
  localparam logic [31:0] RELOAD_RESET = 32'h0001_0000;
  localparam logic [14:0] LIMIT_RESET = 15'h6000;
  localparam logic [31:0] RELOAD_MIN = 32'h0000_0004;

  // Sticky event bits of the event status, clear and enable registers.
  localparam int EVT_CORR_A = 0;
  localparam int EVT_UNCORR_A = 1;
  localparam int EVT_CORR_SWEEP = 2;
  localparam int EVT_WRAP = 3;
  localparam int EVT_W = 4;

  // Number of error tallies and their slots.
  localparam int TALLY_N = 3;
  localparam int T_CORR_A = 0;
  localparam int T_CORR_SWEEP = 1;
  localparam int T_UNCORR_A = 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic corrected;
    logic uncorrectable;
    logic [16:0] addr;
  } port_a_evt_t;

  typedef struct packed {
    logic valid;
    logic corrected;
    logic uncorrectable;
  } sweep_evt_t;

  typedef struct packed {
    logic req;
    logic [14:0] addr;
  } scrub_req_t;

endpackage : ecc_scrub_pkg

// ==== hw/scrub_sequencer.sv ====
// Scrub pacing timer and address walker that drive the memory's scrub port.
// Assumes the memory acknowledges a scrub access with a one-cycle ack while req is high.
module scrub_sequencer (
  input wire logic clk_i, // System clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable, freezes all state when low.
  input wire logic enable_i, // Background scrubbing enabled.
  input wire logic [31:0] reload_i, // Timer reload value from software.
  input wire logic [14:0] limit_i, // Highest address to scrub.
  input wire logic ack_i, // Scrub port accepted the access.
  output ecc_scrub_pkg::scrub_req_t scrub_o, // Scrub request and address.
  output logic [31:0] timer_o, // Current timer value.
  output logic wrap_o // One-cycle pulse when the walk restarts at zero.
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_COUNT = 3'b010,
    ST_ISSUE = 3'b100
  } seq_state_t;

  seq_state_t state_reg;
  seq_state_t state_next;
  logic [31:0] timer_reg;
  logic [31:0] timer_next;
  logic [14:0] addr_reg;
  logic [14:0] addr_next;
  logic wrap_reg;
  logic wrap_next;
  logic [31:0] reload_eff;
  logic at_limit;

  // A reload below the minimum would let requests pile up faster than the port serves them.
  assign reload_eff = (reload_i < ecc_scrub_pkg::RELOAD_MIN) ? ecc_scrub_pkg::RELOAD_MIN
                                                              : reload_i;
  assign at_limit = (addr_reg >= limit_i);

  // Next-state logic; an access already issued is completed even if scrubbing is switched off.
  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    addr_next = addr_reg;
    wrap_next = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (enable_i)
        begin
          timer_next = reload_eff;
          state_next = ST_COUNT;
        end
      end
      ST_COUNT:
      begin
        if (!enable_i)
        begin
          state_next = ST_IDLE;
        end
        else if (timer_reg <= 32'h0000_0001)
        begin
          timer_next = 32'h0000_0000;
          state_next = ST_ISSUE;
        end
        else
        begin
          timer_next = timer_reg - 32'h0000_0001;
        end
      end
      ST_ISSUE:
      begin
        if (ack_i)
        begin
          addr_next = at_limit ? 15'h0000 : addr_reg + 15'h0001;
          wrap_next = at_limit;
          timer_next = reload_eff;
          state_next = enable_i ? ST_COUNT : ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= ST_IDLE;
      timer_reg <= 32'h0000_0000;
      addr_reg <= 15'h0000;
      wrap_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      addr_reg <= addr_next;
      wrap_reg <= wrap_next;
    end
  end

  assign scrub_o.req = (state_reg == ST_ISSUE);
  assign scrub_o.addr = addr_reg;
  assign timer_o = timer_reg;
  assign wrap_o = wrap_reg;

endmodule : scrub_sequencer

// ==== hw/sram_ecc_scrubber_status.sv ====
// Error monitor and scrub status registers of an error-corrected dual-port memory.
// Assumes port A and scrub-port error reports arrive as one-cycle pulses in the clk_i domain.
//
// Operation
// - Set the port A uncorrectable flag, bit 0, on a port A multi-bit error when enabled.
// - The uncorrectable flag stays set until software writes its register with anything.
// - Scrub addresses advance up to the 15-bit limit, then restart at zero; limit resets 0x6000.
// - Sixteen-bit tally of corrected port A read errors; any write clears it.
// - Sixteen-bit tally of errors corrected by the scrub; any write clears it.
// - Sixteen-bit tally of port A multi-bit read errors; any write clears it.
// - Control bit 2 gates the uncorrectable interrupt; resets cleared, the flag cannot set while clear, but enabled sticky events still interrupt.
// - Control bit 0 enables scrubbing when one; it resets to one.
// - Pacing timer counts down from the reload; reload must be at least four cycles.
// - Capture the 17-bit port A address of the latest multi-bit error, overwriting.
//
// The strobed register port was chosen for this implementation.
module sram_ecc_scrubber_status (
  input wire logic clk_i, // System clock, 40 MHz.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable, freezes all state when low.
  input ecc_scrub_pkg::reg_req_t bus_i, // Register port request.
  output logic [31:0] rdata_o, // Read data, valid the cycle after a read strobe.
  input ecc_scrub_pkg::port_a_evt_t port_a_i, // Port A read error report.
  input ecc_scrub_pkg::sweep_evt_t sweep_i, // Scrub port error report.
  input wire logic scrub_ack_i, // Scrub port accepted the request.
  output ecc_scrub_pkg::scrub_req_t scrub_o, // Scrub request to the memory.
  output logic uncorrectable_a_flag_o, // Port A uncorrectable flag level.
  output logic irq_o // Interrupt, high while an enabled cause is set.
);

  // Address decode of the register port.
  logic sel_control;
  logic sel_timer_count;
  logic sel_reload;
  logic sel_flag;
  logic sel_limit;
  logic sel_corr_a;
  logic sel_corr_sweep;
  logic sel_uncorr_a;
  logic sel_last_addr;
  logic sel_evt_status;
  logic sel_evt_clear;
  logic sel_evt_enable;

  assign sel_control = (bus_i.addr == ecc_scrub_pkg::ADDR_CONTROL);
  assign sel_timer_count = (bus_i.addr == ecc_scrub_pkg::ADDR_TIMER_COUNT);
  assign sel_reload = (bus_i.addr == ecc_scrub_pkg::ADDR_TIMER_RELOAD);
  assign sel_flag = (bus_i.addr == ecc_scrub_pkg::ADDR_IRQ_FLAG);
  assign sel_limit = (bus_i.addr == ecc_scrub_pkg::ADDR_UPPER_LIMIT);
  assign sel_corr_a = (bus_i.addr == ecc_scrub_pkg::ADDR_CORR_A);
  assign sel_corr_sweep = (bus_i.addr == ecc_scrub_pkg::ADDR_CORR_SWEEP);
  assign sel_uncorr_a = (bus_i.addr == ecc_scrub_pkg::ADDR_UNCORR_A);
  assign sel_last_addr = (bus_i.addr == ecc_scrub_pkg::ADDR_LAST_ADDR);
  assign sel_evt_status = (bus_i.addr == ecc_scrub_pkg::ADDR_EVT_STATUS);
  assign sel_evt_clear = (bus_i.addr == ecc_scrub_pkg::ADDR_EVT_CLEAR);
  assign sel_evt_enable = (bus_i.addr == ecc_scrub_pkg::ADDR_EVT_ENABLE);

  // Write strobes per register.
  logic wr_control;
  logic wr_reload;
  logic wr_flag;
  logic wr_limit;
  logic wr_evt_clear;
  logic wr_evt_enable;

  assign wr_control = bus_i.wr & sel_control;
  assign wr_reload = bus_i.wr & sel_reload;
  assign wr_flag = bus_i.wr & sel_flag;
  assign wr_limit = bus_i.wr & sel_limit;
  assign wr_evt_clear = bus_i.wr & sel_evt_clear;
  assign wr_evt_enable = bus_i.wr & sel_evt_enable;

  // Error events qualified by their report strobes.
  logic ev_corr_a;
  logic ev_uncorr_a;
  logic ev_corr_sweep;

  assign ev_corr_a = port_a_i.valid & port_a_i.corrected;
  assign ev_uncorr_a = port_a_i.valid & port_a_i.uncorrectable;
  assign ev_corr_sweep = sweep_i.valid & sweep_i.corrected;

  // Software-controlled state.
  logic scrub_en_reg;
  logic irq_en_reg;
  logic [31:0] reload_reg;
  logic [14:0] limit_reg;
  logic flag_reg;
  logic flag_next;
  logic [16:0] last_addr_reg;
  logic [3:0] evt_status_reg;
  logic [3:0] evt_status_next;
  logic [3:0] evt_enable_reg;
  logic [3:0] evt_set;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;

  // Sequencer results.
  logic [31:0] timer_value;
  logic wrap_pulse;

  // Control register: only the scrub enable and interrupt enable bits are stored.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      scrub_en_reg <= ecc_scrub_pkg::CTRL_SCRUB_EN_RESET;
      irq_en_reg <= ecc_scrub_pkg::CTRL_IRQ_EN_RESET;
    end
    else if (ce_i && wr_control)
    begin
      scrub_en_reg <= bus_i.wdata[ecc_scrub_pkg::CTRL_SCRUB_EN_BIT];
      irq_en_reg <= bus_i.wdata[ecc_scrub_pkg::CTRL_IRQ_EN_BIT];
    end
  end

  // Timer reload; the full word is stored so software reads back what it wrote.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      reload_reg <= ecc_scrub_pkg::RELOAD_RESET;
    end
    else if (ce_i && wr_reload)
    begin
      reload_reg <= bus_i.wdata;
    end
  end

  // Scrub upper limit, 15 bits; the upper bits of the write are dropped.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      limit_reg <= ecc_scrub_pkg::LIMIT_RESET;
    end
    else if (ce_i && wr_limit)
    begin
      limit_reg <= bus_i.wdata[ecc_scrub_pkg::LIMIT_W-1:0];
    end
  end

  // Uncorrectable flag: a new error in the clearing cycle keeps the flag set so none is lost.
  assign flag_next = (ev_uncorr_a & irq_en_reg) ? 1'b1
                   : (wr_flag ? 1'b0 : flag_reg);

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      flag_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      flag_reg <= flag_next;
    end
  end

  // Address of the latest uncorrectable port A read, captured whatever the interrupt enable.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      last_addr_reg <= 17'h00000;
    end
    else if (ce_i && ev_uncorr_a)
    begin
      last_addr_reg <= port_a_i.addr;
    end
  end

  // Error tallies share one structure; index order follows the T_ slots in the package.
  logic [ecc_scrub_pkg::TALLY_N-1:0] tally_inc;
  logic [ecc_scrub_pkg::TALLY_N-1:0] tally_clr;
  logic [15:0] tally_val [ecc_scrub_pkg::TALLY_N];

  assign tally_inc[ecc_scrub_pkg::T_CORR_A] = ev_corr_a;
  assign tally_inc[ecc_scrub_pkg::T_CORR_SWEEP] = ev_corr_sweep;
  assign tally_inc[ecc_scrub_pkg::T_UNCORR_A] = ev_uncorr_a;
  assign tally_clr[ecc_scrub_pkg::T_CORR_A] = bus_i.wr & sel_corr_a;
  assign tally_clr[ecc_scrub_pkg::T_CORR_SWEEP] = bus_i.wr & sel_corr_sweep;
  assign tally_clr[ecc_scrub_pkg::T_UNCORR_A] = bus_i.wr & sel_uncorr_a;

  // Saturating tallies: wrapping would make a storm of errors look like a quiet memory.
  genvar gi;
  generate
    for (gi = 0; gi < ecc_scrub_pkg::TALLY_N; gi++)
    begin : g_tally
      logic [15:0] cnt_reg;
      logic [15:0] cnt_next;

      assign cnt_next = tally_clr[gi] ? 16'h0000
                      : ((tally_inc[gi] && (cnt_reg != 16'hFFFF)) ? cnt_reg + 16'h0001
                                                                  : cnt_reg);

      always_ff @(posedge clk_i)
      begin
        if (!reset_n_i)
        begin
          cnt_reg <= 16'h0000;
        end
        else if (ce_i)
        begin
          cnt_reg <= cnt_next;
        end
      end

      assign tally_val[gi] = cnt_reg;
    end
  endgenerate

  // Sticky event status; set wins over a same-cycle clear so an event is never lost.
  assign evt_set[ecc_scrub_pkg::EVT_CORR_A] = ev_corr_a;
  assign evt_set[ecc_scrub_pkg::EVT_UNCORR_A] = ev_uncorr_a;
  assign evt_set[ecc_scrub_pkg::EVT_CORR_SWEEP] = ev_corr_sweep;
  assign evt_set[ecc_scrub_pkg::EVT_WRAP] = wrap_pulse;
  assign evt_status_next = evt_set
                         | (evt_status_reg
                            & ~(wr_evt_clear ? bus_i.wdata[ecc_scrub_pkg::EVT_W-1:0] : 4'h0));

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      evt_status_reg <= 4'h0;
      evt_enable_reg <= 4'h0;
    end
    else if (ce_i)
    begin
      evt_status_reg <= evt_status_next;
      if (wr_evt_enable)
      begin
        evt_enable_reg <= bus_i.wdata[ecc_scrub_pkg::EVT_W-1:0];
      end
    end
  end

  // Background scrub pacing and address walk.
  scrub_sequencer u_seq (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .enable_i(scrub_en_reg),
    .reload_i(reload_reg),
    .limit_i(limit_reg),
    .ack_i(scrub_ack_i),
    .scrub_o(scrub_o),
    .timer_o(timer_value),
    .wrap_o(wrap_pulse)
  );

  // Read selection; unmapped and write-only addresses read as zero.
  assign rd_mux =
      ({32{sel_control}} & {29'h0, irq_en_reg, 1'b0, scrub_en_reg})
    | ({32{sel_timer_count}} & timer_value)
    | ({32{sel_reload}} & reload_reg)
    | ({32{sel_flag}} & {31'h0, flag_reg})
    | ({32{sel_limit}} & {17'h0, limit_reg})
    | ({32{sel_corr_a}} & {16'h0, tally_val[ecc_scrub_pkg::T_CORR_A]})
    | ({32{sel_corr_sweep}} & {16'h0, tally_val[ecc_scrub_pkg::T_CORR_SWEEP]})
    | ({32{sel_uncorr_a}} & {16'h0, tally_val[ecc_scrub_pkg::T_UNCORR_A]})
    | ({32{sel_last_addr}} & {15'h0, last_addr_reg})
    | ({32{sel_evt_status}} & {28'h0, evt_status_reg})
    | ({32{sel_evt_enable}} & {28'h0, evt_enable_reg});

  // Read data stand only in the cycle after the strobe and are zero otherwise.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      rdata_reg <= bus_i.rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_reg;
  assign uncorrectable_a_flag_o = flag_reg;
  // The documented flag and the enabled sticky events share the single interrupt line.
  assign irq_o = flag_reg | (|(evt_status_reg & evt_enable_reg));

endmodule : sram_ecc_scrubber_status

// ==== verif/scrub_status_checker_assertions.sv ====
// Checker for the error monitor and scrub status block, bound to its top module.
// Assumes ce_i stays high; shadows of control and limit writes stand in for taps.
module scrub_status_checker (
  input wire logic clk_i, // System clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input ecc_scrub_pkg::reg_req_t bus_i, // Register request.
  input wire logic [31:0] rdata_o, // Read data.
  input ecc_scrub_pkg::port_a_evt_t port_a_i, // Port A report.
  input wire logic scrub_ack_i, // Scrub ack.
  input ecc_scrub_pkg::scrub_req_t scrub_o, // Scrub request.
  input wire logic uncorrectable_a_flag_o, // Uncorrectable flag.
  input wire logic irq_o // Interrupt.
);
  logic irq_en_reg;
  logic scrub_en_reg;
  logic [14:0] limit_reg;

  // Decoded events seen at the ports.
  wire ctl_wr = bus_i.wr && bus_i.addr == ecc_scrub_pkg::ADDR_CONTROL;
  wire lim_wr = bus_i.wr && bus_i.addr == ecc_scrub_pkg::ADDR_UPPER_LIMIT;
  wire flag_wr = bus_i.wr && bus_i.addr == ecc_scrub_pkg::ADDR_IRQ_FLAG;
  wire mbe = port_a_i.valid && port_a_i.uncorrectable;
  wire step = scrub_o.req && scrub_ack_i;

  // Shadows follow register writes, so no internal signal has to be probed.
  always_ff @(posedge clk_i)
  begin
    irq_en_reg <= !reset_n_i ? 1'b0 : ctl_wr ? bus_i.wdata[2] : irq_en_reg;
    scrub_en_reg <= !reset_n_i ? 1'b1 : ctl_wr ? bus_i.wdata[0] : scrub_en_reg;
    limit_reg <= !reset_n_i ? 15'h6000 : lim_wr ? bus_i.wdata[14:0] : limit_reg;
  end

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_FLAG_SET: assert property (mbe && irq_en_reg |=> uncorrectable_a_flag_o)
    else $error("flag not set by port A multi-bit error");
  AST_IRQ_FLAG: assert property (uncorrectable_a_flag_o |-> irq_o)
    else $error("interrupt low while flag set");
  AST_FLAG_HOLD: assert property (uncorrectable_a_flag_o && !flag_wr
    |=> uncorrectable_a_flag_o)
    else $error("flag dropped without a write");
  AST_FLAG_CLEAR: assert property (flag_wr && !(mbe && irq_en_reg)
    |=> !uncorrectable_a_flag_o)
    else $error("flag not cleared by write");
  AST_FLAG_GATED: assert property (!uncorrectable_a_flag_o && !irq_en_reg
    |=> !uncorrectable_a_flag_o)
    else $error("flag set while interrupt disabled");
  AST_REQ_HOLD: assert property (scrub_o.req && !scrub_ack_i
    |=> scrub_o.req && $stable(scrub_o.addr))
    else $error("scrub request changed before ack");
  AST_ADVANCE: assert property (step |=> !scrub_o.req && scrub_o.addr ==
    ($past(scrub_o.addr) >= $past(limit_reg) ? 15'h0 : $past(scrub_o.addr) + 15'h1))
    else $error("scrub address did not advance or wrap");
  AST_STOPPED: assert property (!scrub_en_reg && $past(!scrub_en_reg)
    && !scrub_o.req |=> !scrub_o.req)
    else $error("scrub request while disabled");
  AST_REQ_GAP: assert property ($fell(scrub_o.req) |-> !scrub_o.req [*4])
    else $error("scrub requests closer than four cycles");
  AST_TALLY_UPPER: assert property (bus_i.rd
    && bus_i.addr == ecc_scrub_pkg::ADDR_UNCORR_A |=> rdata_o[31:16] == 16'h0)
    else $error("tally upper bits not zero");

  // Main scenarios reached.
  cover property (step && scrub_o.addr == limit_reg);
  cover property (mbe && irq_en_reg);
  cover property (flag_wr && uncorrectable_a_flag_o);
endmodule : scrub_status_checker

// ==== verif/scrub_memory_model.sv ====
// Behavioural scrub port of the error-corrected memory.
// Assumes the block holds its request until it samples ack high.
module scrub_memory_model (
  input wire logic clk_i, // System clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input ecc_scrub_pkg::scrub_req_t scrub_i, // Scrub request.
  input wire logic [3:0] delay_i, // Wait cycles before ack.
  input wire logic corrupt_i, // Report a corrected upset.
  output logic ack_o, // Access accepted.
  output ecc_scrub_pkg::sweep_evt_t sweep_o // Completion report.
);
  logic [3:0] wait_reg;

  // Ack is one pulse given only while req stands, so a slow answer is also tried.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || ack_o || !scrub_i.req)
    begin
      ack_o <= 1'b0;
      wait_reg <= 4'h0;
    end
    else if (wait_reg == delay_i)
    begin
      ack_o <= 1'b1;
    end
    else
    begin
      wait_reg <= wait_reg + 4'h1;
    end
  end

  // The completion report rides with the ack.
  assign sweep_o = '{valid: ack_o, corrected: ack_o && corrupt_i, uncorrectable: 1'b0};
endmodule : scrub_memory_model

// ==== verif/testbench.sv ====
// Self-checking bench for the error monitor and scrub status block.
// Assumes the memory model on the scrub port; ce_i is held high throughout.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  ecc_scrub_pkg::reg_req_t bus_i = '0;
  ecc_scrub_pkg::port_a_evt_t port_a_i = '0;
  ecc_scrub_pkg::sweep_evt_t sweep;
  ecc_scrub_pkg::scrub_req_t scrub;
  logic [31:0] rdata;
  logic scrub_ack;
  logic flag;
  logic irq;
  logic [3:0] delay = 4'h0;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  logic [14:0] seen[$];

  // A 40 MHz clock.
  always #12.5 clk_i = ~clk_i;

  sram_ecc_scrubber_status i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .bus_i(bus_i), .rdata_o(rdata), .port_a_i(port_a_i), .sweep_i(sweep),
    .scrub_ack_i(scrub_ack), .scrub_o(scrub), .uncorrectable_a_flag_o(flag), .irq_o(irq));

  scrub_memory_model i_mem (.clk_i(clk_i), .reset_n_i(reset_n_i), .scrub_i(scrub),
    .delay_i(delay), .corrupt_i(1'b1), .ack_o(scrub_ack), .sweep_o(sweep));

  // Scrub addresses at each accepted access, and a ceiling on run length.
  always @(posedge clk_i)
  begin
    cycles++;
    if (scrub.req === 1'b1 && scrub_ack === 1'b1)
      seen.push_back(scrub.addr);
    if (cycles == 90000)
    begin
      errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Each access leaves a gap cycle, so no strobe is driven twice at one edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus_i <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_i);
    bus_i <= '0;
    #1;
    chk(rdata, exp);
  endtask : rd

  task automatic pa(input logic c, input logic u, input logic [16:0] a);
    @(posedge clk_i);
    port_a_i <= '{valid: 1'b1, corrected: c, uncorrectable: u, addr: a};
    @(posedge clk_i);
    port_a_i <= '0;
    #1;
  endtask : pa

  task automatic results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // Main sequence: reset values, scrub walk, port A reports, events.
  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(ecc_scrub_pkg::ADDR_CONTROL, 32'h1);
    rd(ecc_scrub_pkg::ADDR_UPPER_LIMIT, 32'h6000);
    rd(ecc_scrub_pkg::ADDR_TIMER_RELOAD, 32'h0001_0000);
    rd(ecc_scrub_pkg::ADDR_CORR_A, 32'h0);
    rd(ecc_scrub_pkg::ADDR_CORR_SWEEP, 32'h0);
    rd(ecc_scrub_pkg::ADDR_UNCORR_A, 32'h0);
    rd(ecc_scrub_pkg::ADDR_IRQ_FLAG, 32'h0);
    rd(8'h3C, 32'h0);
    // Restart the walk with the shortest legal spacing and a limit of 2.
    wr(ecc_scrub_pkg::ADDR_CONTROL, 32'h0);
    wr(ecc_scrub_pkg::ADDR_TIMER_RELOAD, 32'h4);
    wr(ecc_scrub_pkg::ADDR_UPPER_LIMIT, 32'h2);
    seen.delete();
    wr(ecc_scrub_pkg::ADDR_CONTROL, 32'h1);
    for (n = 0; seen.size() < 3 && n < 300; n++)
      @(posedge clk_i);
    delay <= 4'h3;
    for (n = 0; seen.size() < 6 && n < 300; n++)
      @(posedge clk_i);
    wr(ecc_scrub_pkg::ADDR_CONTROL, 32'h0);
    repeat (20) @(posedge clk_i);
    n = seen.size();
    repeat (40) @(posedge clk_i);
    chk(32'(seen.size()), 32'(n));
    // The stop lands while the pacing timer still runs, so exactly six accesses were made.
    chk(32'(n), 32'h6);
    for (int i = 0; i < 6; i++)
      chk({17'h0, seen[i]}, 32'(i % 3));
    rd(ecc_scrub_pkg::ADDR_CORR_SWEEP, 32'h6);
    wr(ecc_scrub_pkg::ADDR_CORR_SWEEP, 32'hFFFF);
    rd(ecc_scrub_pkg::ADDR_CORR_SWEEP, 32'h0);
    // Port A reports with the interrupt off, then on.
    repeat (3) pa(1'b1, 1'b0, 17'h0);
    rd(ecc_scrub_pkg::ADDR_CORR_A, 32'h3);
    pa(1'b0, 1'b1, 17'h00123);
    chk({30'h0, flag, irq}, 32'h0);
    rd(ecc_scrub_pkg::ADDR_UNCORR_A, 32'h1);
    rd(ecc_scrub_pkg::ADDR_LAST_ADDR, 32'h123);
    wr(ecc_scrub_pkg::ADDR_CONTROL, 32'h4);
    pa(1'b0, 1'b1, 17'h1ABCD);
    chk({30'h0, flag, irq}, 32'h3);
    rd(ecc_scrub_pkg::ADDR_LAST_ADDR, 32'h1ABCD);
    rd(ecc_scrub_pkg::ADDR_IRQ_FLAG, 32'h1);
    wr(ecc_scrub_pkg::ADDR_IRQ_FLAG, 32'h0);
    #1;
    chk({30'h0, flag, irq}, 32'h0);
    // A clearing write beats a report in the same cycle.
    @(posedge clk_i);
    port_a_i <= '{valid: 1'b1, corrected: 1'b1, uncorrectable: 1'b0, addr: 17'h0};
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: ecc_scrub_pkg::ADDR_CORR_A, wdata: 32'h0};
    @(posedge clk_i);
    port_a_i <= '0;
    bus_i <= '0;
    rd(ecc_scrub_pkg::ADDR_CORR_A, 32'h0);
    // Back-to-back reports past the tally's range must stick at all ones.
    wr(ecc_scrub_pkg::ADDR_CONTROL, 32'h0);
    @(posedge clk_i);
    port_a_i <= '{valid: 1'b1, corrected: 1'b0, uncorrectable: 1'b1, addr: 17'h0};
    repeat (65540) @(posedge clk_i);
    port_a_i <= '0;
    rd(ecc_scrub_pkg::ADDR_UNCORR_A, 32'hFFFF);
    chk({31'h0, flag}, 32'h0);
    // Event interrupt: cleared, raised, masked, cleared again.
    wr(ecc_scrub_pkg::ADDR_EVT_CLEAR, 32'hF);
    rd(ecc_scrub_pkg::ADDR_EVT_STATUS, 32'h0);
    wr(ecc_scrub_pkg::ADDR_EVT_ENABLE, 32'h1);
    pa(1'b1, 1'b0, 17'h0);
    chk({31'h0, irq}, 32'h1);
    rd(ecc_scrub_pkg::ADDR_EVT_STATUS, 32'h1);
    wr(ecc_scrub_pkg::ADDR_EVT_ENABLE, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr(ecc_scrub_pkg::ADDR_EVT_ENABLE, 32'h1);
    wr(ecc_scrub_pkg::ADDR_EVT_CLEAR, 32'h1);
    #1;
    chk({31'h0, irq}, 32'h0);
    results();
  end
endmodule : testbench

bind sram_ecc_scrubber_status scrub_status_checker i_chk (.clk_i, .reset_n_i, .bus_i,
  .rdata_o, .port_a_i, .scrub_ack_i, .scrub_o, .uncorrectable_a_flag_o, .irq_o);
